// ===== logic/ccarb_pkg.sv
// Shared constants for control channel arbitration
package ccarb_pkg;

    // ------------------------------------------------------------
    // Clock and bus timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_QUARTER_NS = 2500; // Quarter of a 100 kHz SCL period
    localparam int SCL_QUARTER_CYC_INT =
        (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] SCL_QUARTER_CYC = 10'(SCL_QUARTER_CYC_INT);
    localparam logic [9:0] SCL_HALF_CYC = 10'(2 * SCL_QUARTER_CYC_INT);
    localparam logic [4:0] PROXY_LAST_BIT = 5'h11; // 18 bits per transfer
    localparam logic [1:0] STRAP_LOAD_CYC = 2'h3;  // Strap passes sync first

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_DEVICE_ID = 8'h00;
    localparam logic [7:0] OFF_OWNERSHIP_TOKEN_A = 8'h18;
    localparam logic [7:0] OFF_OWNERSHIP_TOKEN_B = 8'h19;
    localparam logic [7:0] OFF_PROXY_CTRL = 8'hD0;
    localparam logic [7:0] OFF_PROXY_TARGET = 8'hD1;
    localparam logic [7:0] OFF_PROXY_DATA = 8'hD2;
    localparam logic [7:0] OFF_PROXY_STATUS = 8'hD3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_GO_BIT = 0;       // Self-clearing start
    localparam int CTRL_DISPLAY_BIT = 1;  // Direction: 1 display, 0 camera
    localparam int STAT_BUSY_BIT = 0;     // Read only
    localparam int STAT_LOST_BIT = 1;     // Latched high, clear on read
    localparam int STAT_NACK_BIT = 2;     // Read to clear
    localparam int STAT_DONE_BIT = 3;     // Latched high, clear on read
    localparam int STAT_REFUSED_BIT = 4;  // Latched high, clear on read

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TOKEN = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_TARGET = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [4:0] RST_STATUS = 5'h00;

    // ------------------------------------------------------------
    // Proxy controller states, Gray along the usual path except DONE to IDLE
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CCARB_IDLE = 3'h0,
        CCARB_WAIT = 3'h1,
        CCARB_START = 3'h3,
        CCARB_LOW = 3'h2,
        CCARB_HIGH = 3'h6,
        CCARB_STOP = 3'h7,
        CCARB_DONE = 3'h5
    } ccarb_state_type;

endpackage : ccarb_pkg

// ===== logic/ccarb_proxy.sv
// Proxy I2C controller with bitwise arbitration and retry
`timescale 1ns/100ps
module ccarb_proxy (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [6:0] target,
    input wire logic [7:0] data,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe,
    output logic sda_oe,
    output logic busy,
    output logic done,
    output logic lost,
    output logic nack
);

    ccarb_pkg::ccarb_state_type state, next_state;
    logic [9:0] cnt, next_cnt;
    logic [4:0] bitn, next_bitn;
    logic [17:0] pattern, next_pattern;
    logic next_scl_oe, next_sda_oe, next_done, next_lost, next_nack;
    logic bus_busy, next_bus_busy, scl_q, sda_q;
    logic cur_bit, is_ack, bus_idle;

    // --------------------------------------------------------------------
    // Bus monitor
    // --------------------------------------------------------------------
    // Start sets busy, stop clears it; idle needs both lines high
    always_comb begin
        next_bus_busy = bus_busy;
        if (scl_in && scl_q && sda_q && !sda_in) begin
            next_bus_busy = 1'b1;
        end
        if (scl_in && scl_q && !sda_q && sda_in) begin
            next_bus_busy = 1'b0;
        end
    end
    assign bus_idle = !bus_busy && scl_in && sda_in;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_busy <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            bus_busy <= next_bus_busy;
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // --------------------------------------------------------------------
    // Bit engine
    // --------------------------------------------------------------------
    assign cur_bit = pattern[17];
    assign is_ack = (bitn == 5'h08) || (bitn == ccarb_pkg::PROXY_LAST_BIT);

    // Next state, line drive and results
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_bitn = bitn;
        next_pattern = pattern;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_done = 1'b0;
        next_lost = 1'b0;
        next_nack = nack;
        case (state)
            ccarb_pkg::CCARB_IDLE: begin
                if (start) begin
                    next_pattern = {target, 1'b0, 1'b1, data, 1'b1};
                    next_nack = 1'b0;
                    next_state = ccarb_pkg::CCARB_WAIT;
                end
            end
            ccarb_pkg::CCARB_WAIT: begin
                next_cnt = 10'h000;
                next_bitn = 5'h00;
                if (bus_idle) begin
                    next_sda_oe = 1'b1; // Start: SDA low under high SCL
                    next_state = ccarb_pkg::CCARB_START;
                end
            end
            ccarb_pkg::CCARB_START: begin
                next_cnt = cnt + 10'h001;
                if (cnt == ccarb_pkg::SCL_QUARTER_CYC) begin
                    next_scl_oe = 1'b1;
                    next_cnt = 10'h000;
                    next_state = ccarb_pkg::CCARB_LOW;
                end
            end
            ccarb_pkg::CCARB_LOW: begin
                next_cnt = cnt + 10'h001;
                if (cnt == ccarb_pkg::SCL_QUARTER_CYC) begin
                    next_sda_oe = !cur_bit; // Release for one, pull for zero
                end
                if (cnt == ccarb_pkg::SCL_HALF_CYC) begin
                    next_scl_oe = 1'b0;
                    next_cnt = 10'h000;
                    next_state = ccarb_pkg::CCARB_HIGH;
                end
            end
            ccarb_pkg::CCARB_HIGH: begin
                if (scl_in) begin // Target stretch holds count
                    next_cnt = cnt + 10'h001;
                end
                if (scl_in && cnt == ccarb_pkg::SCL_QUARTER_CYC) begin
                    next_cnt = 10'h000;
                    next_scl_oe = 1'b1;
                    next_pattern = {pattern[16:0], 1'b1};
                    next_bitn = bitn + 5'h01;
                    if (cur_bit && !sda_in && !is_ack) begin
                        next_sda_oe = 1'b0; // Release SDA and SCL at once
                        next_scl_oe = 1'b0;
                        next_lost = 1'b1;
                        next_pattern = {target, 1'b0, 1'b1, data, 1'b1};
                        next_state = ccarb_pkg::CCARB_WAIT;
                    end else if (is_ack && sda_in) begin
                        next_nack = 1'b1;
                        next_state = ccarb_pkg::CCARB_STOP;
                    end else if (bitn == ccarb_pkg::PROXY_LAST_BIT) begin
                        next_state = ccarb_pkg::CCARB_STOP;
                    end else begin
                        next_state = ccarb_pkg::CCARB_LOW;
                    end
                end
            end
            ccarb_pkg::CCARB_STOP: begin
                // Every transfer ends in stop, never repeated start
                if (cnt < ccarb_pkg::SCL_QUARTER_CYC || scl_in) begin
                    next_cnt = cnt + 10'h001;
                end
                if (cnt == 10'h000) begin
                    next_sda_oe = 1'b1;
                end
                if (cnt == ccarb_pkg::SCL_QUARTER_CYC) begin
                    next_scl_oe = 1'b0;
                end
                if (cnt == ccarb_pkg::SCL_HALF_CYC) begin
                    next_sda_oe = 1'b0;
                    next_state = ccarb_pkg::CCARB_DONE;
                end
            end
            ccarb_pkg::CCARB_DONE: begin
                next_done = 1'b1;
                next_state = ccarb_pkg::CCARB_IDLE;
            end
            default: begin
                next_scl_oe = 1'b0;
                next_sda_oe = 1'b0;
                next_state = ccarb_pkg::CCARB_IDLE;
            end
        endcase
    end

    // Engine registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ccarb_pkg::CCARB_IDLE;
            cnt <= 10'h000;
            bitn <= 5'h00;
            pattern <= 18'h00000;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            done <= 1'b0;
            lost <= 1'b0;
            nack <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            bitn <= next_bitn;
            pattern <= next_pattern;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            done <= next_done;
            lost <= next_lost;
            nack <= next_nack;
            busy <= (next_state != ccarb_pkg::CCARB_IDLE);
        end
    end

endmodule : ccarb_proxy

// ===== logic/ccarb_top.sv
// Register arbitration and proxy controller top for the control channel
`timescale 1ns/100ps
module ccarb_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [6:0] strap_id,
    input wire logic loc_req,
    input wire logic loc_wr,
    input wire logic [7:0] loc_offset,
    input wire logic [7:0] loc_wdata,
    output logic loc_ack,
    output logic loc_err,
    output logic [7:0] loc_rdata,
    input wire logic rem_req,
    input wire logic rem_wr,
    input wire logic rem_offset_sent,
    input wire logic [7:0] rem_offset,
    input wire logic [7:0] rem_wdata,
    output logic rem_ack,
    output logic rem_err,
    output logic [7:0] rem_rdata,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe,
    output logic sda_oe
);

    // --------------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------------
    logic [1:0] scl_sync, sda_sync;
    logic [6:0] strap_meta, strap_sync;

    // Two stages for every asynchronous pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            strap_meta <= 7'h00;
            strap_sync <= 7'h00;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            strap_meta <= strap_id;
            strap_sync <= strap_meta;
        end
    end

    // --------------------------------------------------------------------
    // Arbiter and register file
    // --------------------------------------------------------------------
    logic [7:0] dev_id, next_dev_id;
    logic [7:0] token_a, next_token_a, token_b, next_token_b;
    logic [7:0] ctrl, next_ctrl, target, next_target, pdata, next_pdata;
    logic [4:0] status, next_status;
    logic [1:0] strap_cnt, next_strap_cnt;
    logic last_rem, next_last_rem;
    logic next_loc_ack, next_rem_ack, next_loc_err, next_rem_err;
    logic [7:0] next_loc_rdata, next_rem_rdata;
    logic go_pulse, next_go_pulse;
    logic p_busy, p_done, p_lost, p_nack;
    logic p_scl_oe, p_sda_oe;
    logic loc_pend, rem_pend, grant_rem, grant_any;
    logic acc_wr, acc_src_ok, acc_rd_bad;
    logic [7:0] acc_off, acc_wdata, rd_val;

    // One access per cycle, alternate when both wait
    assign loc_pend = loc_req && !loc_ack;
    assign rem_pend = rem_req && !rem_ack;
    assign grant_rem = rem_pend && (!loc_pend || !last_rem);
    assign grant_any = loc_pend || rem_pend;
    assign acc_wr = grant_rem ? rem_wr : loc_wr;
    assign acc_off = grant_rem ? rem_offset : loc_offset;
    assign acc_wdata = grant_rem ? rem_wdata : loc_wdata;
    assign acc_rd_bad = grant_rem && !rem_wr && !rem_offset_sent;
    // Display mode serves the far side, camera mode the near side
    assign acc_src_ok = grant_rem == ctrl[ccarb_pkg::CTRL_DISPLAY_BIT];

    // Read multiplexer, unmapped offsets read zero
    always_comb begin
        case (acc_off)
            ccarb_pkg::OFF_DEVICE_ID: rd_val = dev_id;
            ccarb_pkg::OFF_OWNERSHIP_TOKEN_A: rd_val = token_a;
            ccarb_pkg::OFF_OWNERSHIP_TOKEN_B: rd_val = token_b;
            ccarb_pkg::OFF_PROXY_CTRL: rd_val = ctrl;
            ccarb_pkg::OFF_PROXY_TARGET: rd_val = target;
            ccarb_pkg::OFF_PROXY_DATA: rd_val = pdata;
            ccarb_pkg::OFF_PROXY_STATUS: rd_val = {3'h0, status};
            default: rd_val = 8'h00;
        endcase
    end

    // Next values of registers and answers
    always_comb begin
        next_dev_id = dev_id;
        next_token_a = token_a;
        next_token_b = token_b;
        next_ctrl = ctrl;
        next_target = target;
        next_pdata = pdata;
        next_status = status;
        next_strap_cnt = strap_cnt;
        next_last_rem = last_rem;
        next_go_pulse = 1'b0;
        next_loc_ack = 1'b0;
        next_rem_ack = 1'b0;
        next_loc_err = 1'b0;
        next_rem_err = 1'b0;
        next_loc_rdata = loc_rdata;
        next_rem_rdata = rem_rdata;
        // Strap load once synchronised, later writes override
        if (strap_cnt != ccarb_pkg::STRAP_LOAD_CYC) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt + 2'h1 == ccarb_pkg::STRAP_LOAD_CYC) begin
                next_dev_id = {strap_sync, 1'b0};
            end
        end
        next_status[ccarb_pkg::STAT_BUSY_BIT] = p_busy;
        if (grant_any) begin
            next_last_rem = grant_rem;
            next_loc_ack = !grant_rem;
            next_rem_ack = grant_rem;
            next_rem_err = acc_rd_bad;
            if (grant_rem) begin
                next_rem_rdata = acc_rd_bad ? 8'h00 : rd_val;
            end else begin
                next_loc_rdata = rd_val;
            end
            if (acc_wr) begin
                case (acc_off)
                    ccarb_pkg::OFF_DEVICE_ID: next_dev_id = acc_wdata;
                    ccarb_pkg::OFF_OWNERSHIP_TOKEN_A: begin
                        next_token_a = acc_wdata;
                    end
                    ccarb_pkg::OFF_OWNERSHIP_TOKEN_B: begin
                        next_token_b = acc_wdata;
                    end
                    ccarb_pkg::OFF_PROXY_CTRL: begin
                        next_ctrl = acc_wdata & 8'h02; // Go is not stored
                        if (acc_wdata[ccarb_pkg::CTRL_GO_BIT]) begin
                            if (acc_src_ok && !p_busy) begin
                                next_go_pulse = 1'b1;
                            end else begin
                                next_status[ccarb_pkg::STAT_REFUSED_BIT] = 1'b1;
                            end
                        end
                    end
                    ccarb_pkg::OFF_PROXY_TARGET: next_target = acc_wdata;
                    ccarb_pkg::OFF_PROXY_DATA: next_pdata = acc_wdata;
                    default: next_dev_id = dev_id; // Reserved
                endcase
            end else if (!acc_rd_bad &&
                         acc_off == ccarb_pkg::OFF_PROXY_STATUS) begin
                // Latched and clear-on-read bits clear on read
                next_status[ccarb_pkg::STAT_LOST_BIT] = 1'b0;
                next_status[ccarb_pkg::STAT_NACK_BIT] = 1'b0;
                next_status[ccarb_pkg::STAT_DONE_BIT] = 1'b0;
                next_status[ccarb_pkg::STAT_REFUSED_BIT] = 1'b0;
            end
        end
        // Hardware sets win over a clearing read
        if (p_lost) begin
            next_status[ccarb_pkg::STAT_LOST_BIT] = 1'b1;
        end
        if (p_done) begin
            next_status[ccarb_pkg::STAT_DONE_BIT] = 1'b1;
            next_status[ccarb_pkg::STAT_NACK_BIT] = p_nack;
        end
    end

    // Register file and answer flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dev_id <= 8'h00;
            token_a <= ccarb_pkg::RST_TOKEN;
            token_b <= ccarb_pkg::RST_TOKEN;
            ctrl <= ccarb_pkg::RST_CTRL;
            target <= ccarb_pkg::RST_TARGET;
            pdata <= ccarb_pkg::RST_DATA;
            status <= ccarb_pkg::RST_STATUS;
            strap_cnt <= 2'h0;
            last_rem <= 1'b0;
            go_pulse <= 1'b0;
            loc_ack <= 1'b0;
            rem_ack <= 1'b0;
            loc_err <= 1'b0;
            rem_err <= 1'b0;
            loc_rdata <= 8'h00;
            rem_rdata <= 8'h00;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            dev_id <= next_dev_id;
            token_a <= next_token_a;
            token_b <= next_token_b;
            ctrl <= next_ctrl;
            target <= next_target;
            pdata <= next_pdata;
            status <= next_status;
            strap_cnt <= next_strap_cnt;
            last_rem <= next_last_rem;
            go_pulse <= next_go_pulse;
            loc_ack <= next_loc_ack;
            rem_ack <= next_rem_ack;
            loc_err <= next_loc_err;
            rem_err <= next_rem_err;
            loc_rdata <= next_loc_rdata;
            rem_rdata <= next_rem_rdata;
            scl_oe <= p_scl_oe;
            sda_oe <= p_sda_oe;
        end
    end

    // --------------------------------------------------------------------
    // Proxy controller on the target bus
    // --------------------------------------------------------------------
    ccarb_proxy u_proxy (
        .clk(clk),
        .rst_n(rst_n),
        .start(go_pulse),
        .target(target[6:0]),
        .data(pdata),
        .scl_in(scl_sync[1]),
        .sda_in(sda_sync[1]),
        .scl_oe(p_scl_oe),
        .sda_oe(p_sda_oe),
        .busy(p_busy),
        .done(p_done),
        .lost(p_lost),
        .nack(p_nack)
    );

endmodule : ccarb_top

// ===== verification/ccarb_top_sva.sv
// Concurrent checks on the arbitration top ports
`timescale 1ns/100ps
module ccarb_top_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic loc_req,
    input wire logic loc_ack,
    input wire logic loc_err,
    input wire logic rem_req,
    input wire logic rem_wr,
    input wire logic rem_offset_sent,
    input wire logic rem_ack,
    input wire logic rem_err,
    input wire logic [7:0] rem_rdata,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Register ports and bus lines
    // ------------------------------------------------------------
    AST_SHORT_READ_ERR: assert property (
        rem_req && !rem_wr && !rem_offset_sent && !rem_ack
        |-> ##[1:2] (rem_ack && rem_err))
        else $error("short read not refused");
    AST_ERR_ZERO_DATA: assert property (
        rem_err |-> rem_ack && rem_rdata == 8'h00)
        else $error("refused read gave data");
    AST_GOOD_READ: assert property (
        rem_ack && $past(rem_wr || rem_offset_sent) |-> !rem_err)
        else $error("proper access refused");
    AST_LOC_NO_ERR: assert property (!loc_err)
        else $error("local port error");
    AST_LOC_ANSWER: assert property (
        loc_req && !loc_ack |-> ##[1:2] loc_ack)
        else $error("local access unanswered");
    AST_REM_ANSWER: assert property (
        rem_req && !rem_ack |-> ##[1:2] rem_ack)
        else $error("remote access unanswered");
    AST_ACK_PULSE: assert property (
        loc_ack |-> $past(loc_req) ##1 !loc_ack)
        else $error("local ack without request");
    AST_START_IDLE: assert property (
        $rose(sda_oe) && !scl_oe |-> scl_in && $past(sda_in))
        else $error("start on busy bus");
    AST_STRETCH_HOLD: assert property (
        !scl_oe && !scl_in && $past(!scl_oe && !scl_in)
        |-> $stable(sda_oe))
        else $error("data moved while clock stretched");
endmodule : ccarb_top_sva

bind ccarb_top ccarb_top_sva i_sva (
    .clk(clk), .rst_n(rst_n), .loc_req(loc_req), .loc_ack(loc_ack),
    .loc_err(loc_err), .rem_req(rem_req), .rem_wr(rem_wr),
    .rem_offset_sent(rem_offset_sent), .rem_ack(rem_ack),
    .rem_err(rem_err), .rem_rdata(rem_rdata), .scl_in(scl_in),
    .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe)
);

// ===== verification/ccarb_bus_partner.sv
// Bus partner: pull-ups, one write target, stretch and a rival low
`timescale 1ns/100ps
module ccarb_bus_partner #(
    parameter logic [6:0] ADDR = 7'h3A
) (
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic stretch,
    input wire logic rival,
    output logic scl_in,
    output logic sda_in,
    output logic [7:0] rx_byte
);
    logic ack_oe = 1'b0;
    logic hold_oe = 1'b0;
    logic hit = 1'b0;
    logic [7:0] sh = 8'h00;
    int nbit = 0;
    // Released lines float to the pull-up level
    assign scl_in = !(scl_oe || hold_oe);
    assign sda_in = !(sda_oe || ack_oe || rival);
    // A start restarts the bit count
    always @(negedge sda_in) begin
        if (scl_in) begin
            nbit = 0;
        end
    end
    // Bits shift in on rising clock
    always @(posedge scl_in) begin
        sh = {sh[6:0], sda_in};
    end
    // Count, acknowledge and stretch on falling clock
    always @(negedge scl_in) begin
        nbit = nbit + 1;
        if (nbit == 9) begin
            hit = (sh == {ADDR, 1'b0});
        end
        if (nbit == 18) begin
            rx_byte = sh;
        end
        ack_oe = hit && (nbit == 9 || nbit == 18);
        if (stretch) begin
            hold_oe = 1'b1;
            #8000 hold_oe = 1'b0;
        end
    end
endmodule : ccarb_bus_partner

// ===== verification/ccarb_top_tb_top.sv
// Self-checking bench for the arbitration top
`timescale 1ns/100ps
module ccarb_top_tb_top;
    localparam logic [6:0] STRAP = 7'h35;
    localparam logic [6:0] TGT = 7'h3A;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osent = 1'b1;
    logic stretch = 1'b0;
    logic rival = 1'b0;
    logic [1:0] req = 2'h0;
    logic [1:0] wr = 2'h0;
    logic [1:0][7:0] off = 16'h0000;
    logic [1:0][7:0] wd = 16'h0000;
    wire [1:0] ack;
    wire [1:0] err;
    wire [1:0][7:0] rd;
    wire scl_in, sda_in, scl_oe, sda_oe;
    wire [7:0] rx_byte;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    ccarb_top i_dut (
        .clk(clk), .rst_n(rst_n), .strap_id(STRAP),
        .loc_req(req[0]), .loc_wr(wr[0]), .loc_offset(off[0]),
        .loc_wdata(wd[0]), .loc_ack(ack[0]), .loc_err(err[0]),
        .loc_rdata(rd[0]), .rem_req(req[1]), .rem_wr(wr[1]),
        .rem_offset_sent(osent), .rem_offset(off[1]),
        .rem_wdata(wd[1]), .rem_ack(ack[1]), .rem_err(err[1]),
        .rem_rdata(rd[1]), .scl_in(scl_in), .sda_in(sda_in),
        .scl_oe(scl_oe), .sda_oe(sda_oe)
    );
    ccarb_bus_partner #(.ADDR(TGT)) i_bus (
        .scl_oe(scl_oe), .sda_oe(sda_oe), .stretch(stretch),
        .rival(rival), .scl_in(scl_in), .sda_in(sda_in),
        .rx_byte(rx_byte)
    );
    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            n_mismatch++;
            $display("Error timeout expected done seen hang");
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] x,
            input logic [7:0] g);
        checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic acc(input int r, input logic w, input logic [7:0] o,
            input logic [7:0] d, output logic [7:0] q, output logic e);
        int n;
        n = 0;
        wr[r] = w;
        off[r] = o;
        wd[r] = d;
        req[r] = 1'b1;
        do begin
            @(posedge clk) #1;
            n++;
        end while (ack[r] !== 1'b1 && n < 8);
        chk("ack", 8'h01, {7'h00, ack[r]});
        q = rd[r];
        e = err[r];
        @(posedge clk) #1;
        req[r] = 1'b0;
        @(posedge clk) #1;
    endtask : acc
    task automatic wrr(input int r, input logic [7:0] o, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        acc(r, 1'b1, o, d, q, e);
    endtask : wrr
    task automatic rdc(input int r, input logic [7:0] o,
            input logic [7:0] x, input string nm);
        logic [7:0] q;
        logic e;
        acc(r, 1'b0, o, 8'h00, q, e);
        chk(nm, x, q);
    endtask : rdc
    task automatic xfer(input logic [6:0] a, input logic [7:0] d,
            input bit rv, output logic [7:0] st);
        logic [7:0] q;
        logic e;
        st = 8'h00;
        wrr(1, 8'hD1, {1'b0, a});
        wrr(1, 8'hD2, d);
        wrr(1, 8'hD0, 8'h03);
        if (rv) begin
            wait (sda_oe === 1'b1);
            wait (sda_oe === 1'b0);
            @(posedge clk) #1;
            rival = 1'b1;
            repeat (1500) @(posedge clk);
            #1 rival = 1'b0;
        end
        for (int i = 0; i < 400 && st[3] !== 1'b1; i++) begin
            repeat (100) @(posedge clk);
            #1;
            acc(1, 1'b0, 8'hD3, 8'h00, q, e);
            st = st | q;
        end
    endtask : xfer
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [7:0] q;
        logic e;
        rdc(0, 8'h00, {STRAP, 1'b0}, "device id");
        rdc(1, 8'h18, 8'h00, "token a reset");
        wrr(0, 8'h00, 8'hA5);
        rdc(1, 8'h00, 8'hA5, "id rewrite");
        wrr(1, 8'h40, 8'h77);
        rdc(0, 8'h40, 8'h00, "reserved");
        wrr(0, 8'h19, 8'h3C);
        osent = 1'b0;
        acc(1, 1'b0, 8'h19, 8'h00, q, e);
        osent = 1'b1;
        chk("short read err", 8'h01, {7'h00, e});
        chk("short read data", 8'h00, q);
        $display("test registers done");
    endtask : t_regs
    task automatic t_conc;
        logic [7:0] a, b;
        logic e;
        fork
            wrr(0, 8'h18, 8'h11);
            wrr(1, 8'h18, 8'h22);
        join
        acc(0, 1'b0, 8'h18, 8'h00, a, e);
        acc(1, 1'b0, 8'h18, 8'h00, b, e);
        chk("same reg", 8'h01, {7'h00, (a === 8'h11 || a === 8'h22)
            && b === a});
        fork
            wrr(0, 8'h18, 8'h5A);
            wrr(1, 8'h19, 8'hC6);
        join
        fork
            rdc(1, 8'h18, 8'h5A, "token a");
            rdc(0, 8'h19, 8'hC6, "token b");
        join
        $display("test concurrent done");
    endtask : t_conc
    task automatic t_dir;
        wrr(0, 8'hD0, 8'h02);
        wrr(0, 8'hD0, 8'h03);
        rdc(0, 8'hD0, 8'h02, "go self clear");
        rdc(0, 8'hD3, 8'h10, "go refused");
        rdc(0, 8'hD3, 8'h00, "status cleared");
        $display("test direction done");
    endtask : t_dir
    task automatic t_link;
        logic [7:0] st;
        stretch = 1'b1;
        xfer(TGT, 8'hC3, 1'b0, st);
        stretch = 1'b0;
        chk("stretch status", 8'h08, st & 8'h0E);
        chk("stretch data", 8'hC3, rx_byte);
        xfer(TGT, 8'h5E, 1'b1, st);
        chk("loss status", 8'h0A, st & 8'h0E);
        chk("retry data", 8'h5E, rx_byte);
        xfer(TGT ^ 7'h01, 8'h96, 1'b0, st);
        chk("nack status", 8'h0C, st & 8'h0E);
        rdc(1, 8'hD3, 8'h00, "nack cleared");
        $display("test link done");
    endtask : t_link
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_regs();
        t_conc();
        t_dir();
        t_link();
        stop_test();
    end
endmodule : ccarb_top_tb_top
